// >>> tb_token_flow_and_pu_control.sv
// Purpose: Self-checking bench for stream ops and PU control decode
// Assumes: 100 MHz clock, synchronous active-low reset
// Notes:   Token rows are checked on the third falling edge after launch
`timescale 1ns/10ps
module tb_token_flow_and_pu_control;
   import token_flow_pkg::*;
   typedef struct packed {
      logic [31:0] cfg;
      logic        mk;
      logic [7:0]  id;
      logic [17:0] dat;
      logic        ev;
      logic        epo;
      logic [7:0]  eid;
   } row_t;
   localparam int NR = 30;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] d;
   token_t      send = '0;
   token_t      tok;
   out_token_t  tok_out;
   logic        pv = 1'b0;
   pu_word_t    pw = '0;
   operand_t    a = '0, b = '0, x, y, qa, qb;
   operand_t    rx = 18'h0aaaa, ry = 18'h35555;
   res_flags_t  fl = '0;
   logic        pv_o, two_o, po;
   pu_ctl_t     ctl;
   op_class_t   cls;
   int          mismatches = 0, total_checks = 0, ncyc = 0;
   int          qi[$], qd[$];
   row_t rows [NR] = '{
      '{32'h3011,0,8'h10,0,1,0,8'h10}, '{0,0,8'h10,0,1,0,8'h10},
      '{0,0,8'h10,0,1,1,8'h10}, '{0,1,8'h10,0,1,1,8'h10},
      '{0,0,8'h10,0,1,0,8'h10}, '{0,0,8'h10,0,1,0,8'h10},
      '{0,0,8'h10,0,1,1,8'h10}, '{0,0,8'h10,0,1,1,8'h10},
      '{32'h12,0,8'h20,0,1,0,8'h20}, '{0,0,8'h20,0,1,0,8'h20},
      '{0,0,8'h20,0,1,1,8'h20}, '{0,1,8'h20,0,0,0,0},
      '{0,0,8'h20,0,1,0,8'h20}, '{0,0,8'h20,0,1,0,8'h20},
      '{32'h100003,0,8'h05,0,1,0,8'h05}, '{0,1,8'h05,0,1,0,8'h05},
      '{0,0,8'h05,0,1,0,8'h06}, '{0,1,8'h05,0,1,0,8'h06},
      '{0,0,8'h05,0,1,0,8'h05},
      '{32'h4,0,8'h09,18'h3a5a5,0,0,0}, '{0,1,8'h07,18'h1,1,0,8'ha5},
      '{0,0,8'h09,18'h30,0,0,0}, '{0,1,8'h07,18'h2,1,0,8'h30},
      '{32'h25,0,8'h11,0,0,0,0}, '{0,0,8'h11,0,0,0,0},
      '{0,0,8'h11,0,1,0,8'h11}, '{0,0,8'h11,0,1,0,8'h11},
      '{0,1,8'h11,0,0,0,0}, '{0,0,8'h11,0,0,0,0}, '{0,0,8'h11,0,0,0,0}};

   always #5 clk = ~clk;

   upstream_stage_model upstream_stage_model_i (.core_clk_i(clk),
      .reset_n_i(rst_n), .send_i(send), .tok_o(tok));
   token_flow_and_pu_control token_flow_and_pu_control_i (
      .core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .tok_i(tok), .tok_o(tok_out),
      .pu_valid_i(pv), .pu_word_i(pw), .opnd_a_i(a), .opnd_b_i(b),
      .res_x_i(rx), .res_y_i(ry), .res_flags_i(fl), .pu_valid_o(pv_o),
      .pu_ctl_o(ctl), .pu_class_o(cls), .two_operand_o(two_o),
      .queue_a_o(qa), .queue_b_o(qb), .pu_x_o(x), .pu_y_o(y),
      .pu_plus_one_o(po));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] ad, input logic [31:0] v);
      @(posedge clk);
      addr <= ad;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] ad, output logic [31:0] v);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask : rd_reg

   function automatic op_class_t ecls(input logic [4:0] o);
      case (o)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h0c: return CLASS_LOGIC;
         5'h04, 5'h05, 5'h06, 5'h07: return CLASS_SHIFT;
         5'h08, 5'h09, 5'h11: return CLASS_COMPARE;
         5'h0d, 5'h10, 5'h15, 5'h16, 5'h17: return CLASS_BIT;
         5'h0e, 5'h0f: return CLASS_CONVERT;
         5'h12, 5'h13, 5'h14: return CLASS_MISC;
         default: return CLASS_ARITH;
      endcase
   endfunction : ecls

   task automatic do_reset;
      @(posedge clk);
      send <= '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic pu_chk(input pu_word_t w, input operand_t aa, bb,
                         input res_flags_t f,
                         input operand_t ex, ey, eqa, eqb,
                         input logic epo);
      @(posedge clk);
      pv <= 1'b1;
      pw <= w;
      a <= aa;
      b <= bb;
      fl <= f;
      @(posedge clk);
      @(negedge clk);
      chk("pu_valid", 1, pv_o);
      chk("pu_ctl", w[11:0], ctl);
      chk("pu_class", ecls(w.op), cls);
      chk("two_operand", w[13], two_o);
      chk("queue_a", eqa, qa);
      chk("queue_b", eqb, qb);
      chk("pu_x", ex, x);
      chk("pu_y", ey, y);
      chk("pu_plus_one", epo, po);
   endtask : pu_chk

   function automatic logic cexp(input logic [2:0] cd,
                                 input res_flags_t f, input logic cin);
      case (cd)
         3'h0: return cin;
         3'h1: return f.zero;
         3'h2: return f.neg;
         3'h3: return f.neg | f.zero;
         3'h4: return !f.neg && !f.zero;
         3'h5: return !f.neg;
         3'h6: return !f.zero;
         default: return f.ovf;
      endcase
   endfunction : cexp

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Token monitor and main sequence
   // ----------------------------------------
   always @(negedge clk) begin
      ncyc = ncyc + 1;
      if (qd.size() > 0 && qd[0] == ncyc) begin
         chk("tok_valid", rows[qi[0]].ev, tok_out.valid);
         if (rows[qi[0]].ev) begin
            chk("tok_plus_one", rows[qi[0]].epo, tok_out.plus_one);
            chk("tok_id", rows[qi[0]].eid, tok_out.id);
            chk("tok_data", rows[qi[0]].dat, tok_out.data);
         end
         void'(qi.pop_front());
         void'(qd.pop_front());
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(4'h0, d);
      chk("cfg_reset", 32'h0, d);
      rd_reg(4'h1, d);
      chk("stat_reset", 32'h0, d);
      wr_reg(4'h0, 32'ha5c3_3c5a);
      rd_reg(4'h0, d);
      chk("cfg", 32'ha5c3_3c5a, d);
      wr_reg(4'h1, 32'hffff_ffff);
      rd_reg(4'h1, d);
      chk("stat_ro", 32'h0, d);
      wr_reg(4'h7, 32'h1234_5678);
      rd_reg(4'h7, d);
      chk("unmapped", 32'h0, d);
      @(negedge clk);
      chk("rdata_idle", 32'h0, rdata);
      pu_chk(14'h3218, 18'h21234, 18'h05678, 3'h4, 18'h2aaaa, 18'h15555,
             18'h05678, 18'h21234, 1'b1);
      pu_chk(14'h2320, 18'h21234, 18'h05678, 3'h4, 18'h21234, 18'h05678,
             18'h21234, 18'h05678, 1'b1);
      pu_chk(14'h1029, 18'h21234, 18'h05678, 3'h4, 18'h2aaaa, 18'h35555,
             18'h21234, 18'h00000, 1'b0);
      pu_chk(14'h2d1b, 18'h21234, 18'h25678, 3'h4, 18'h2aaaa, 18'h35555,
             18'h21234, 18'h25678, 1'b0);
      for (int i = 0; i < 64; i++) begin
         pu_chk({4'h9, 2'b10, i[2:0], i[4:0]}, 18'h21234, 18'h05678,
                i[5:3], {cexp(i[2:0], i[5:3], 1'b1), rx[16:0]},
                {cexp(i[2:0], i[5:3], 1'b0), ry[16:0]}, 18'h21234,
                18'h05678, cexp(i[2:0], i[5:3], 1'b1));
      end
      for (int i = 0; i < NR; i++) begin
         if (rows[i].cfg != 32'h0) begin
            do_reset();
            wr_reg(4'h0, rows[i].cfg);
         end
         @(posedge clk);
         send <= '{1'b1, rows[i].mk, rows[i].id, rows[i].dat};
         qi.push_back(i);
         qd.push_back(ncyc + 3);
      end
      @(posedge clk);
      send <= '0;
      for (int k = 0; k < 8 && qd.size() > 0; k++) @(posedge clk);
      chk("tok_drain", 0, qd.size());
      rd_reg(4'h1, d);
      chk("stat_cut", 32'h2, d);
      do_reset();
      @(negedge clk);
      chk("pu_valid_rst", 0, pv_o);
      chk("tok_rst", 0, tok_out);
      chk("pu_class_rst", 0, cls);
      report_and_stop();
   end
endmodule : tb_token_flow_and_pu_control

// >>> token_flow_and_pu_control.sv
// Purpose: Stream operations and processing unit control decode
// Assumes: Tokens and PU words arrive synchronous to core_clk_i
// Notes:   Outputs are registered, one cycle after the input
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
module token_flow_and_pu_control (
   input  wire logic                      core_clk_i,
   input  wire logic                      reset_n_i,
   input  wire logic [3:0]                reg_addr_i,
   input  wire logic [31:0]               reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [31:0]               reg_rdata_o,
   input  wire token_flow_pkg::token_t    tok_i,
   output token_flow_pkg::out_token_t     tok_o,
   input  wire logic                      pu_valid_i,
   input  wire token_flow_pkg::pu_word_t  pu_word_i,
   input  wire token_flow_pkg::operand_t  opnd_a_i,
   input  wire token_flow_pkg::operand_t  opnd_b_i,
   input  wire token_flow_pkg::operand_t  res_x_i,
   input  wire token_flow_pkg::operand_t  res_y_i,
   input  wire token_flow_pkg::res_flags_t res_flags_i,
   output logic                           pu_valid_o,
   output token_flow_pkg::pu_ctl_t        pu_ctl_o,
   output token_flow_pkg::op_class_t      pu_class_o,
   output logic                           two_operand_o,
   output token_flow_pkg::operand_t       queue_a_o,
   output token_flow_pkg::operand_t       queue_b_o,
   output token_flow_pkg::operand_t       pu_x_o,
   output token_flow_pkg::operand_t       pu_y_o,
   output logic                           pu_plus_one_o
);
   import token_flow_pkg::*;

   // ----------------------------------------
   // Decode functions
   // ----------------------------------------
   function automatic op_class_t op_class(input logic [4:0] op);
      unique case (op)
         OR_OP, AND_OP, XOR_OP, AND_INVERTED_OP, NOT_OP:
            op_class = CLASS_LOGIC;
         SHIFT_LEFT_OP, REVERSED_SHIFT_LEFT_OP, SHIFT_RIGHT_OP,
         REVERSED_SHIFT_RIGHT_OP:
            op_class = CLASS_SHIFT;
         ADD_OP, ADD_ZERO_COUNT_OP, SUBTRACT_OP, SUBTRACT_ZERO_COUNT_OP,
         MULTIPLY_OP, MULTIPLY_ZERO_COUNT_OP, PASS_THROUGH_OP,
         PASS_ZERO_COUNT_OP, INCREMENT_OP, DECREMENT_OP:
            op_class = CLASS_ARITH;
         COMPARE_PLAIN_OP, COMPARE_OP, COMPARE_SWAP_OP:
            op_class = CLASS_COMPARE;
         GET_BIT_OP, SET_BIT_OP, CLEAR_BIT_OP, MASK_AND_CHECK_OP,
         MASK_OR_CHECK_OP:
            op_class = CLASS_BIT;
         TO_SIGN_MAGNITUDE_OP, TO_TWOS_COMPLEMENT_OP:
            op_class = CLASS_CONVERT;
         DOUBLE_PRECISION_ADJUST_OP, ACCUMULATE_OP, CONDITION_COPY_OP:
            op_class = CLASS_MISC;
      endcase
   endfunction : op_class

   function automatic logic cond_true(input logic [2:0] code,
                                      input res_flags_t f);
      unique case (code)
         COND_EQ:  cond_true = f.zero;
         COND_LT:  cond_true = f.neg;
         COND_LE:  cond_true = f.neg | f.zero;
         COND_GT:  cond_true = ~f.neg & ~f.zero;
         COND_GE:  cond_true = ~f.neg;
         COND_NE:  cond_true = ~f.zero;
         COND_OVF: cond_true = f.ovf;
         COND_NONE: cond_true = 1'b0;
      endcase
   endfunction : cond_true

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [31:0]     cfg_reg;
   logic [7:0]      cnt_reg;
   logic            pass_reg;
   logic [ID_W-1:0] offset_reg;
   logic [ID_W-1:0] saved_identifier_reg;
   logic [3:0]      fc_op;
   logic [7:0]      count_size;
   logic [7:0]      divide_size;
   logic [ID_W-1:0] offset_limit;

   assign fc_op        = cfg_reg[CFG_OP_LSB +: 4];
   assign count_size   = cfg_reg[CFG_CS_LSB +: 8];
   assign divide_size  = cfg_reg[CFG_DS_LSB +: 8];
   assign offset_limit = cfg_reg[CFG_LIM_LSB +: ID_W];

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         cfg_reg <= CFG_RESET;
      end else if (reg_wr_i && reg_addr_i == CFG_ADDR) begin
         cfg_reg <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            CFG_ADDR:  reg_rdata_o <= cfg_reg;
            STAT_ADDR: reg_rdata_o <= {7'h00, pass_reg,
                                       saved_identifier_reg,
                                       offset_reg, cnt_reg};
            default:   reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Stream operations
   // ----------------------------------------
   logic            tok_marker;
   logic            tok_plain;
   logic            cnt_in_id;
   logic [7:0]      cnt_next;
   logic            pass_next;
   logic [ID_W-1:0] offset_next;
   logic [ID_W-1:0] saved_next;
   out_token_t      out_next;

   assign tok_marker = tok_i.valid & tok_i.marker;
   assign tok_plain  = tok_i.valid & ~tok_i.marker;
   assign cnt_in_id  = cnt_reg <= count_size;

   always_comb begin
      cnt_next    = cnt_reg;
      pass_next   = pass_reg;
      offset_next = offset_reg;
      saved_next  = saved_identifier_reg;
      out_next    = '{valid: tok_i.valid, plus_one: 1'b0,
                      id: tok_i.id, data: tok_i.data};
      unique case (fc_op)
         CYCLIC_DIVIDE_OP: begin
            if (tok_i.valid) begin
               out_next.plus_one = ~cnt_in_id;
               cnt_next = (cnt_reg >= divide_size) ? 8'h00
                                                   : cnt_reg + 8'h01;
            end
         end
         DIVIDE_OP: begin
            if (tok_marker) begin
               cnt_next       = 8'h00;
               out_next.valid = 1'b0;
            end else if (tok_plain) begin
               out_next.plus_one = ~cnt_in_id;
               if (cnt_in_id) begin
                  cnt_next = cnt_reg + 8'h01;
               end
            end
         end
         DISTRIBUTE_OP: begin
            out_next.id = tok_i.id + offset_reg;
            if (tok_marker) begin
               offset_next = (offset_reg == offset_limit)
                           ? '0 : offset_reg + 1'b1;
            end
         end
         SAVE_ID_OP: begin
            if (tok_plain) begin
               saved_next     = tok_i.data[ID_W-1:0];
               out_next.valid = 1'b0;
            end else if (tok_marker) begin
               out_next.id = saved_identifier_reg;
            end
         end
         STREAM_CUT_OP: begin
            if (tok_marker) begin
               pass_next      = 1'b0;
               cnt_next       = 8'h00;
               out_next.valid = 1'b0;
            end else if (tok_plain && !pass_reg) begin
               if (cnt_reg == count_size) begin
                  pass_next = 1'b1;
               end else begin
                  cnt_next       = cnt_reg + 8'h01;
                  out_next.valid = 1'b0;
               end
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         cnt_reg              <= 8'h00;
         pass_reg             <= 1'b0;
         offset_reg           <= '0;
         saved_identifier_reg <= '0;
         tok_o                <= '0;
      end else begin
         cnt_reg              <= cnt_next;
         pass_reg             <= pass_next;
         offset_reg           <= offset_next;
         saved_identifier_reg <= saved_next;
         tok_o                <= out_next;
      end
   end

   // ----------------------------------------
   // Processing unit control
   // ----------------------------------------
   logic     bypass;
   logic     cond_hit;
   operand_t x_next;
   operand_t y_next;

   assign bypass   = pu_word_i.conditional_bypass_bit
                   & (opnd_a_i.c != opnd_b_i.c);
   assign cond_hit = cond_true(pu_word_i.condition_test_field,
                               res_flags_i);

   always_comb begin
      x_next = res_x_i;
      y_next = res_y_i;
      if (bypass) begin
         x_next = opnd_a_i;
         y_next = opnd_b_i;
      end else if (pu_word_i.condition_test_field == COND_NONE) begin
         x_next.c = opnd_a_i.c;
         y_next.c = opnd_b_i.c;
      end else begin
         x_next.c = cond_hit;
         y_next.c = cond_hit;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         pu_valid_o    <= 1'b0;
         pu_ctl_o      <= '0;
         pu_class_o    <= CLASS_LOGIC;
         two_operand_o <= 1'b0;
         queue_a_o     <= '0;
         queue_b_o     <= '0;
         pu_x_o        <= '0;
         pu_y_o        <= '0;
         pu_plus_one_o <= 1'b0;
      end else begin
         pu_valid_o    <= pu_valid_i;
         pu_ctl_o      <= pu_word_i[11:0];
         pu_class_o    <= op_class(pu_word_i.op);
         two_operand_o <= pu_word_i.two_operand;
         if (pu_word_i.two_operand && pu_word_i.swap_bit) begin
            queue_a_o <= opnd_b_i;
            queue_b_o <= opnd_a_i;
         end else begin
            queue_a_o <= opnd_a_i;
            queue_b_o <= pu_word_i.two_operand ? opnd_b_i : '0;
         end
         pu_x_o        <= x_next;
         pu_y_o        <= y_next;
         pu_plus_one_o <= pu_word_i.branch_control_bit
                        & x_next.c;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_div_marker_drop: assert property (
      tok_marker && fc_op == DIVIDE_OP |=> !tok_o.valid && cnt_reg == 8'h00)
      else $error("divide marker not dropped");
   a_cut_close_gate: assert property (
      tok_marker && fc_op == STREAM_CUT_OP |=> !pass_reg && !tok_o.valid)
      else $error("cut marker did not close gate");
   a_cut_delete_closed: assert property (
      tok_plain && fc_op == STREAM_CUT_OP && !pass_reg
      && cnt_reg != count_size |=> !tok_o.valid && !pass_reg)
      else $error("closed cut passed a token");
   a_save_capture: assert property (
      tok_plain && fc_op == SAVE_ID_OP
      |=> saved_identifier_reg == $past(tok_i.data[ID_W-1:0]))
      else $error("saved identifier not captured");
   a_save_replace: assert property (
      tok_marker && fc_op == SAVE_ID_OP
      |=> tok_o.valid && tok_o.id == $past(saved_identifier_reg))
      else $error("marker identifier not replaced");
   a_distribute_op_wrap: assert property (
      tok_marker && fc_op == DISTRIBUTE_OP && offset_reg == offset_limit
      |=> offset_reg == '0)
      else $error("offset did not wrap");
   a_distribute_op_step: assert property (
      tok_marker && fc_op == DISTRIBUTE_OP && offset_reg != offset_limit
      |=> offset_reg == ID_W'($past(offset_reg) + 1'b1))
      else $error("offset did not step");
   a_cyc_route: assert property (
      tok_i.valid && fc_op == CYCLIC_DIVIDE_OP
      |=> tok_o.valid && tok_o.plus_one == ($past(cnt_reg) > count_size))
      else $error("cyclic divide misrouted");
   a_bypass_pass: assert property (
      pu_valid_i && bypass |=> pu_x_o == $past(opnd_a_i)
      && pu_y_o == $past(opnd_b_i))
      else $error("bypass altered operands");
   a_branch_route: assert property (
      reset_n_i && pu_valid_i && !pu_word_i.branch_control_bit
      |=> !pu_plus_one_o)
      else $error("branch without control bit");

   a_branch_take: assert property (
      reset_n_i && pu_valid_i && pu_word_i.branch_control_bit && bypass
      |=> pu_plus_one_o == $past(opnd_a_i.c))
      else $error("branch on bypass wrong");

   // ----------------------------------------
   // Stream checks
   // ----------------------------------------
   a_cyc_wrap: assert property (
      tok_i.valid && fc_op == CYCLIC_DIVIDE_OP && cnt_reg >= divide_size
      |=> cnt_reg == 8'h00)
      else $error("cyclic count no wrap");

   a_div_route: assert property (
      tok_plain && fc_op == DIVIDE_OP
      |=> tok_o.valid && tok_o.plus_one == ($past(cnt_reg) > count_size))
      else $error("divide misrouted");

   a_distribute_op_id: assert property (
      tok_i.valid && fc_op == DISTRIBUTE_OP
      |=> tok_o.id == ID_W'($past(tok_i.id) + $past(offset_reg)))
      else $error("distribute id wrong");

   a_distribute_op_hold: assert property (
      tok_plain && fc_op == DISTRIBUTE_OP |=> $stable(offset_reg))
      else $error("offset moved");

   a_cut_open: assert property (
      tok_plain && fc_op == STREAM_CUT_OP && cnt_reg == count_size
      |=> pass_reg && tok_o.valid)
      else $error("cut gate not opened");

   a_cut_pass_open: assert property (
      tok_plain && fc_op == STREAM_CUT_OP && pass_reg
      |=> pass_reg && tok_o.valid)
      else $error("open cut deleted");

   // ----------------------------------------
   // Processing unit checks
   // ----------------------------------------
   a_ctl_strip: assert property (
      reset_n_i && pu_valid_i
      |=> pu_ctl_o == $past(pu_word_i[11:0]))
      else $error("control not stripped");

   a_swap_queue: assert property (
      reset_n_i && pu_valid_i && pu_word_i.two_operand && pu_word_i.swap_bit
      |=> queue_a_o == $past(opnd_b_i) && queue_b_o == $past(opnd_a_i))
      else $error("operands not swapped");

   a_one_operand: assert property (
      reset_n_i && pu_valid_i && !pu_word_i.two_operand
      |=> queue_a_o == $past(opnd_a_i) && queue_b_o == '0)
      else $error("one operand queue wrong");

   a_cond_none: assert property (
      reset_n_i && pu_valid_i && !bypass
      && pu_word_i.condition_test_field == COND_NONE
      |=> pu_x_o.c == $past(opnd_a_i.c) && pu_y_o.c == $past(opnd_b_i.c))
      else $error("condition not copied");

   a_cond_both: assert property (
      pu_valid_i && !bypass && pu_word_i.condition_test_field != COND_NONE
      |=> pu_x_o.c == pu_y_o.c)
      else $error("condition bits differ");
endmodule : token_flow_and_pu_control

// >>> token_flow_pkg.sv
// Purpose: Constants and types for the token flow and PU control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Token identifiers are eight bits wide
package token_flow_pkg;
   localparam int ID_W   = 8;
   localparam int DATA_W = 18;
   // ----------------------------------------
   // Register map and fields
   // ----------------------------------------
   localparam logic [3:0] CFG_ADDR  = 4'h0;
   localparam logic [3:0] STAT_ADDR = 4'h1;
   localparam int CFG_OP_LSB  = 0;
   localparam int CFG_CS_LSB  = 4;
   localparam int CFG_DS_LSB  = 12;
   localparam int CFG_LIM_LSB = 20;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // ----------------------------------------
   // Stream operation codes
   // ----------------------------------------
   localparam logic [3:0] PASS_OP           = 4'h0;
   localparam logic [3:0] CYCLIC_DIVIDE_OP  = 4'h1;
   localparam logic [3:0] DIVIDE_OP         = 4'h2;
   localparam logic [3:0] DISTRIBUTE_OP     = 4'h3;
   localparam logic [3:0] SAVE_ID_OP        = 4'h4;
   localparam logic [3:0] STREAM_CUT_OP     = 4'h5;
   // ----------------------------------------
   // Condition test codes
   // ----------------------------------------
   localparam logic [2:0] COND_NONE = 3'h0;
   localparam logic [2:0] COND_EQ   = 3'h1;
   localparam logic [2:0] COND_LT   = 3'h2;
   localparam logic [2:0] COND_LE   = 3'h3;
   localparam logic [2:0] COND_GT   = 3'h4;
   localparam logic [2:0] COND_GE   = 3'h5;
   localparam logic [2:0] COND_NE   = 3'h6;
   localparam logic [2:0] COND_OVF  = 3'h7;
   // ----------------------------------------
   // Processing unit operation codes
   // ----------------------------------------
   localparam logic [4:0] OR_OP                      = 5'h00;
   localparam logic [4:0] AND_OP                     = 5'h01;
   localparam logic [4:0] XOR_OP                     = 5'h02;
   localparam logic [4:0] AND_INVERTED_OP            = 5'h03;
   localparam logic [4:0] NOT_OP                     = 5'h0c;
   localparam logic [4:0] SHIFT_LEFT_OP              = 5'h04;
   localparam logic [4:0] REVERSED_SHIFT_LEFT_OP     = 5'h05;
   localparam logic [4:0] SHIFT_RIGHT_OP             = 5'h06;
   localparam logic [4:0] REVERSED_SHIFT_RIGHT_OP    = 5'h07;
   localparam logic [4:0] ADD_OP                     = 5'h18;
   localparam logic [4:0] ADD_ZERO_COUNT_OP          = 5'h1c;
   localparam logic [4:0] SUBTRACT_OP                = 5'h19;
   localparam logic [4:0] SUBTRACT_ZERO_COUNT_OP     = 5'h1d;
   localparam logic [4:0] MULTIPLY_OP                = 5'h1a;
   localparam logic [4:0] MULTIPLY_ZERO_COUNT_OP     = 5'h1e;
   localparam logic [4:0] PASS_THROUGH_OP            = 5'h1b;
   localparam logic [4:0] PASS_ZERO_COUNT_OP         = 5'h1f;
   localparam logic [4:0] INCREMENT_OP               = 5'h0a;
   localparam logic [4:0] DECREMENT_OP               = 5'h0b;
   localparam logic [4:0] COMPARE_PLAIN_OP           = 5'h08;
   localparam logic [4:0] COMPARE_OP                 = 5'h09;
   localparam logic [4:0] COMPARE_SWAP_OP            = 5'h11;
   localparam logic [4:0] GET_BIT_OP                 = 5'h15;
   localparam logic [4:0] SET_BIT_OP                 = 5'h16;
   localparam logic [4:0] CLEAR_BIT_OP               = 5'h17;
   localparam logic [4:0] MASK_AND_CHECK_OP          = 5'h0d;
   localparam logic [4:0] MASK_OR_CHECK_OP           = 5'h10;
   localparam logic [4:0] TO_SIGN_MAGNITUDE_OP       = 5'h0e;
   localparam logic [4:0] TO_TWOS_COMPLEMENT_OP      = 5'h0f;
   localparam logic [4:0] DOUBLE_PRECISION_ADJUST_OP = 5'h14;
   localparam logic [4:0] ACCUMULATE_OP              = 5'h12;
   localparam logic [4:0] CONDITION_COPY_OP          = 5'h13;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      CLASS_LOGIC, CLASS_SHIFT, CLASS_ARITH, CLASS_COMPARE,
      CLASS_BIT, CLASS_CONVERT, CLASS_MISC
   } op_class_t;
   typedef struct packed {
      logic              valid;
      logic              marker;
      logic [ID_W-1:0]   id;
      logic [DATA_W-1:0] data;
   } token_t;
   typedef struct packed {
      logic              valid;
      logic              plus_one;
      logic [ID_W-1:0]   id;
      logic [DATA_W-1:0] data;
   } out_token_t;
   typedef struct packed {
      logic       two_operand;
      logic       swap_bit;
      logic [1:0] out_format;
      logic       branch_control_bit;
      logic       conditional_bypass_bit;
      logic [2:0] condition_test_field;
      logic [4:0] op;
   } pu_word_t;
   typedef struct packed {
      logic [1:0] out_format;
      logic       branch_control_bit;
      logic       conditional_bypass_bit;
      logic [2:0] condition_test_field;
      logic [4:0] op;
   } pu_ctl_t;
   typedef struct packed {
      logic        c;
      logic        s;
      logic [15:0] data;
   } operand_t;
   typedef struct packed {
      logic zero;
      logic neg;
      logic ovf;
   } res_flags_t;
endpackage : token_flow_pkg

// >>> upstream_stage_model.sv
// Purpose: Upstream pipeline stage feeding tokens into the block
// Assumes: Bench hands one token a cycle on send_i
// Notes:   Idle cycles clear valid and show the inverse of the previous cycle's other fields, not a copy
`timescale 1ns/10ps
module upstream_stage_model (
   input  wire logic                   core_clk_i,
   input  wire logic                   reset_n_i,
   input  wire token_flow_pkg::token_t send_i,
   output token_flow_pkg::token_t      tok_o
);
   import token_flow_pkg::*;
   // ----------------------------------------
   // Token launch register
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         tok_o <= '0;
      end else if (send_i.valid) begin
         tok_o <= send_i;
      end else begin
         tok_o <= {1'b0, ~tok_o.marker, ~tok_o.id, ~tok_o.data};
      end
   end
endmodule : upstream_stage_model
